// *** sadc_analog_model.sv ***
// sadc_analog_model.sv - behavioural mux, sample and hold and comparator
// assumes: driven by the routing and tap outputs of sadc_ctrl on the same clock
`timescale 1ns/1ps
module sadc_analog_model (
    input wire logic sys_clk_i,
    input wire logic [2:0] chan_i,
    input wire logic gnd_i,
    input wire logic sampling_i,
    input wire logic [9:0] tap_i,
    output logic comp_o
);
    // ------------------------------------------------------------
    // input levels: a ramp over the codes, code 7 is the reference
    // ------------------------------------------------------------
    logic [9:0] held = 10'h155;

    // tracks while sampling, frozen otherwise so the hold is exact
    always @(posedge sys_clk_i) begin
        if (sampling_i) begin // selected channel, or ground when gnd_i is set, taken as analog input
            held <= gnd_i ? 10'h000 : 10'(chan_i * 131 + 37);
        end
    end
    assign comp_o = held >= tap_i;
endmodule

// *** sadc_ctrl.sv ***
// sadc_ctrl.sv - cpu registers, channel routing and result latching of the 10-bit converter
// assumes: byte-wide cpu read/write strobes on sys_clk_i; analog mux, sampler, resistor string
// and comparator sit outside and report the comparison on comp_gt_i asynchronously
// Operation
// - resolution bit: 0 ten-bit, 1 eight-bit
// - copy approximation into results at end; skipped if a mode write falls in that cycle
// - low result: bits 7..6, rest zero
// - results read-only, cleared by reset
// - eight-bit mode: low upper bits read zero
// - eight-bit mode: high holds whole result
// - channel codes: inputs 0..6, 7 reference
// - discharge bit routes ground to sampler
// - sample 9 ticks, or 3 with lv0 set, then hold until done
// - bit 9 first against half-supply tap
// - bit 8 against three or one quarter
// - after the last bit (ten, or eight in eight-bit mode): latch, interrupt, standby; a mode write in that cycle skips latch and interrupt
// - each run write from standby gives one conversion
// - run write ignored while comparator disabled
// - clearing run aborts conversion to standby
`timescale 1ns/1ps
module sadc_ctrl
    import sadc_pkg::*;
#(
    parameter int CH_BITS = 3
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [19:0] cpu_addr_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic comp_gt_i,
    output logic [2:0] chan_sel_o,
    output logic intref_sel_o,
    output logic gnd_sel_o,
    output logic cmp_enable_o,
    output logic sampling_o,
    output logic holding_o,
    output logic [9:0] tap_o,
    output logic conversion_done_irq_o
);
    sadc_ctrl_t s;
    sadc_ctrl_t next_s;
    logic wr_mode;
    logic wr_res;
    logic wr_test;
    logic wr_chan;
    logic rd_result;
    logic start;
    logic abort;
    logic tick;
    logic seq_done;
    logic [9:0] seq_result;
    logic [2:0] chan_mask;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // divider limit for the conversion clock: fclk/8, /4, /2, /1
    function automatic logic [2:0] div_limit(input logic [1:0] fr);
        case (fr)
            2'h0: div_limit = 3'h7;
            2'h1: div_limit = 3'h3;
            2'h2: div_limit = 3'h1;
            default: div_limit = 3'h0;
        endcase
    endfunction

    // address match, shared by every strobe decode
    function automatic logic hit(input logic [19:0] a, input logic [19:0] target);
        hit = (a == target);
    endfunction

    // ------------------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------------------
    assign wr_mode = cpu_wr_i && hit(cpu_addr_i, `SADC_ADDR_MODE);
    assign wr_res = cpu_wr_i && hit(cpu_addr_i, `SADC_ADDR_RES_SEL);
    assign wr_test = cpu_wr_i && hit(cpu_addr_i, `SADC_ADDR_TEST_SEL);
    assign wr_chan = cpu_wr_i && hit(cpu_addr_i, `SADC_ADDR_CHAN);
    assign rd_result = cpu_rd_i && (hit(cpu_addr_i, `SADC_ADDR_RES_LOW)
                       || hit(cpu_addr_i, `SADC_ADDR_RES_HIGH));
    assign chan_mask = 3'((1 << CH_BITS) - 1);

    // a start needs the comparator already on and no conversion running
    assign start = wr_mode && cpu_wdata_i[`SADC_MODE_RUN_BIT] && s.cmp_en && !s.run;
    // dropping run or the comparator mid-conversion abandons the sequence
    assign abort = wr_mode && s.run && (!cpu_wdata_i[`SADC_MODE_RUN_BIT]
                   || !cpu_wdata_i[`SADC_MODE_CMPE_BIT]);
    assign tick = (s.div == div_limit(s.fr));

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    sadc_sar_seq u_seq (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .start_i(start),
        .abort_i(abort),
        .tick_i(tick),
        .eight_bit_i(s.res8),
        .short_sample_i(s.lv0),
        .comp_i(s.comp),
        .sampling_o(sampling_o),
        .holding_o(holding_o),
        .tap_o(tap_o),
        .done_o(seq_done),
        .result_o(seq_result)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.irq = 1'b0;

        // comparator crosses in from the analog side; a change counts once
        // the second and third stages agree
        next_s.sync1 = comp_gt_i;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        if (s.sync2 == s.sync3) begin
            next_s.comp = s.sync3;
        end

        // conversion clock divider restarts with every conversion
        if (start || tick) begin
            next_s.div = 3'h0;
        end else begin
            next_s.div = s.div + 3'h1;
        end

        // register writes; only the documented bits are kept
        if (wr_mode) begin
            next_s.cmp_en = cpu_wdata_i[`SADC_MODE_CMPE_BIT];
            next_s.fr = {cpu_wdata_i[`SADC_MODE_FR1_BIT], cpu_wdata_i[`SADC_MODE_FR0_BIT]};
            next_s.lv0 = cpu_wdata_i[`SADC_MODE_LV0_BIT];
            if (start) begin
                next_s.run = 1'b1;
            end else if (!cpu_wdata_i[`SADC_MODE_RUN_BIT] || !cpu_wdata_i[`SADC_MODE_CMPE_BIT]) begin
                next_s.run = 1'b0; // stop, or write of 1 refused
            end
        end
        if (wr_res) begin
            next_s.res8 = cpu_wdata_i[`SADC_RES_BIT]; // the only writable bit
        end
        if (wr_test) begin
            next_s.discharge = cpu_wdata_i[`SADC_DISCH_BIT];
        end
        if (wr_chan) begin
            next_s.chan = cpu_wdata_i[`SADC_CHAN_MSB:0] & chan_mask;
        end

        // end of conversion: a mode write in the same cycle suppresses the
        // store and the interrupt; a result read in the same cycle delays
        // the store one cycle so the read sees a consistent old value
        if (seq_done && !wr_mode) begin
            next_s.run = 1'b0; // back to standby
            if (rd_result) begin
                next_s.pend = 1'b1;
                next_s.pend_val = seq_result;
            end else begin
                next_s.res_high = seq_result[9:2];
                next_s.res_low = seq_result[1:0];  // zero in eight-bit mode
                next_s.irq = 1'b1;
            end
        end
        if (s.pend) begin
            next_s.pend = 1'b0;
            next_s.res_high = s.pend_val[9:2];
            next_s.res_low = s.pend_val[1:0];
            next_s.irq = 1'b1;
        end

        // read data registered one cycle after the strobe; unmapped reads 00
        next_s.rdata = 8'h00;
        if (cpu_rd_i) begin
            case (cpu_addr_i)
                `SADC_ADDR_MODE: next_s.rdata = {s.run, 2'b00, s.fr, 1'b0, s.lv0, s.cmp_en};
                `SADC_ADDR_RES_SEL: next_s.rdata = {7'h00, s.res8};
                `SADC_ADDR_TEST_SEL: next_s.rdata = {6'h00, s.discharge, 1'b0};
                `SADC_ADDR_CHAN: next_s.rdata = {5'h00, s.chan};
                `SADC_ADDR_RES_HIGH: next_s.rdata = s.res_high;
                `SADC_ADDR_RES_LOW: next_s.rdata = {s.res_low, 6'h00};
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    // results clear to zero on reset like every other register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign cpu_rdata_o = s.rdata;
    assign chan_sel_o = s.chan;
    assign intref_sel_o = (s.chan == `SADC_CHAN_INTREF); // code 7 picks the reference
    assign gnd_sel_o = s.discharge; // ground overrides the channel mux
    assign cmp_enable_o = s.cmp_en;
    assign conversion_done_irq_o = s.irq;
endmodule

// *** sadc_ctrl_chk.sv ***
// sadc_ctrl_chk.sv - port-level assertions for the converter control
// assumes: bound to sadc_ctrl, defines header on the include path
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_ctrl_chk (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [19:0] cpu_addr_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic [7:0] cpu_rdata_o,
    input wire logic [2:0] chan_sel_o,
    input wire logic intref_sel_o,
    input wire logic gnd_sel_o,
    input wire logic cmp_enable_o,
    input wire logic sampling_o,
    input wire logic holding_o,
    input wire logic [9:0] tap_o,
    input wire logic conversion_done_irq_o
);
    // ------------------------------------------------------------
    // bus, routing and sequencer relations
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    rdata_idle_a:
        assert property (!cpu_rd_i |=> cpu_rdata_o == 8'h00) else $error("rdata not idle");
    low_zero_a:
        assert property (cpu_rd_i && cpu_addr_i == `SADC_ADDR_RES_LOW
            |=> cpu_rdata_o[5:0] == 6'h00) else $error("low result pad bits set");
    irq_pulse_a:
        assert property (conversion_done_irq_o |=> !conversion_done_irq_o)
            else $error("irq longer than one cycle");
    irq_hold_a:
        assert property ($rose(conversion_done_irq_o) |-> !holding_o && !sampling_o
            && ($past(holding_o) || $past(holding_o, 2) || $past(holding_o, 3)))
            else $error("irq without a finished hold");
    hold_excl_a:
        assert property (!(sampling_o && holding_o)) else $error("sample and hold together");
    first_tap_a:
        assert property ($rose(holding_o) |-> tap_o == 10'h200) else $error("first tap wrong");
    second_tap_a:
        assert property (holding_o && $past(holding_o) && $past(tap_o) == 10'h200
            && tap_o != 10'h200 |-> tap_o == 10'h300 || tap_o == 10'h100)
            else $error("second tap wrong");
    ref_dec_a:
        assert property (intref_sel_o == (chan_sel_o == 3'h7)) else $error("reference decode");
    chan_wr_a:
        assert property (cpu_wr_i && cpu_addr_i == `SADC_ADDR_CHAN && !sampling_o && !holding_o
            |=> ({5'h00, chan_sel_o} == ($past(cpu_wdata_i) & 8'h07)))
            else $error("channel write lost");
    gnd_wr_a:
        assert property (cpu_wr_i && cpu_addr_i == `SADC_ADDR_TEST_SEL
            |=> ({6'h00, gnd_sel_o, 1'b0} == ($past(cpu_wdata_i) & 8'h02)))
            else $error("discharge write lost");
    abort_a:
        assert property (cpu_wr_i && cpu_addr_i == `SADC_ADDR_MODE && !cpu_wdata_i[7]
            |-> ##[1:3] !sampling_o && !holding_o) else $error("abort did not stop");
    cmp_wr_a:
        assert property (cpu_wr_i && cpu_addr_i == `SADC_ADDR_MODE
            |=> cmp_enable_o == $past(cpu_wdata_i[0])) else $error("enable write lost");
    run_refused_a:
        assert property (cpu_wr_i && cpu_addr_i == `SADC_ADDR_MODE && !cmp_enable_o
            |=> !sampling_o && !holding_o) else $error("run started with comparator off");
endmodule

bind sadc_ctrl sadc_ctrl_chk sadc_ctrl_chk_i (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .chan_sel_o(chan_sel_o),
    .intref_sel_o(intref_sel_o), .gnd_sel_o(gnd_sel_o), .sampling_o(sampling_o),
    .holding_o(holding_o), .tap_o(tap_o), .cmp_enable_o(cmp_enable_o),
    .conversion_done_irq_o(conversion_done_irq_o));

// *** sadc_defines.svh ***
// sadc_defines.svh - offsets, field positions, reset values and counts of the converter control
// assumes: included by the package and the modules of the converter control block
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH

// ----------------------------------------------------------------------------
// register addresses (cpu byte addresses)
// ----------------------------------------------------------------------------
`define SADC_ADDR_RES_SEL   20'hF0010
`define SADC_ADDR_TEST_SEL  20'hF0013
`define SADC_ADDR_RES_LOW   20'hFFF1E
`define SADC_ADDR_RES_HIGH  20'hFFF1F
`define SADC_ADDR_MODE      20'hFFF30
`define SADC_ADDR_CHAN      20'hFFF31

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SADC_MODE_RUN_BIT   7
`define SADC_MODE_FR1_BIT   4
`define SADC_MODE_FR0_BIT   3
`define SADC_MODE_LV0_BIT   1
`define SADC_MODE_CMPE_BIT  0
`define SADC_RES_BIT        0
`define SADC_DISCH_BIT      1
`define SADC_CHAN_MSB       2

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define SADC_REG_RST        8'h00
`define SADC_SAR_BITS       10
`define SADC_SAR_FIRST      10'h200
`define SADC_IDX_MSB        4'h9
`define SADC_IDX_LSB10      4'h0
`define SADC_IDX_LSB8       4'h2
`define SADC_SAMPLE_LONG    4'h9
`define SADC_SAMPLE_SHORT   4'h3
`define SADC_CHAN_INTREF    3'h7

`endif

// *** sadc_pkg.sv ***
// sadc_pkg.sv - types shared by the converter control and its sequencer
// assumes: sadc_defines.svh is on the include path
package sadc_pkg;
`include "sadc_defines.svh"

    // sequencer phases
    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_SAMPLE,
        SQ_CONVERT
    } sadc_seq_state_t;

    // complete state of the sequencer
    typedef struct packed {
        sadc_seq_state_t state;
        logic [3:0] cnt;
        logic [3:0] idx;
        logic [9:0] sar;
        logic [9:0] result;
        logic done;
    } sadc_seq_t;

    // complete state of the register and control side
    typedef struct packed {
        logic run;
        logic cmp_en;
        logic [1:0] fr;
        logic lv0;
        logic res8;
        logic discharge;
        logic [2:0] chan;
        logic [7:0] res_high;
        logic [1:0] res_low;
        logic pend;
        logic [9:0] pend_val;
        logic irq;
        logic [7:0] rdata;
        logic [2:0] div;
        logic sync1;
        logic sync2;
        logic sync3;
        logic comp;
    } sadc_ctrl_t;
endpackage

// *** sadc_sar_seq.sv ***
// sadc_sar_seq.sv - sample, hold and bit-by-bit successive approximation sequencer
// assumes: tick_i is a one-cycle enable at the conversion clock rate, comp_i is already synchronised
`timescale 1ns/1ps
module sadc_sar_seq
    import sadc_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic tick_i,
    input wire logic eight_bit_i,
    input wire logic short_sample_i,
    input wire logic comp_i,
    output logic sampling_o,
    output logic holding_o,
    output logic [9:0] tap_o,
    output logic done_o,
    output logic [9:0] result_o
);
    sadc_seq_t s;
    sadc_seq_t next_s;
    logic [3:0] last_idx;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    // an abort wins over a tick so a cleared run bit never yields a result
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        last_idx = eight_bit_i ? `SADC_IDX_LSB8 : `SADC_IDX_LSB10;
        case (s.state)
            SQ_IDLE: begin
                if (start_i) begin
                    next_s.state = SQ_SAMPLE; // sample first
                    next_s.cnt = (short_sample_i ? `SADC_SAMPLE_SHORT : `SADC_SAMPLE_LONG) - 4'h1;
                    next_s.sar = '0;
                end
            end
            SQ_SAMPLE: begin
                if (abort_i) begin
                    next_s.state = SQ_IDLE;
                end else if (tick_i) begin
                    if (s.cnt == 4'h0) begin
                        next_s.state = SQ_CONVERT;  // switch to hold
                        next_s.sar = `SADC_SAR_FIRST; // trial bit 9 at half tap
                        next_s.idx = `SADC_IDX_MSB;
                    end else begin
                        next_s.cnt = s.cnt - 4'h1;
                    end
                end
            end
            SQ_CONVERT: begin
                if (abort_i) begin
                    next_s.state = SQ_IDLE;
                end else if (tick_i) begin
                    next_s.sar[s.idx] = comp_i; // keep bit if sample at or above tap
                    if (s.idx == last_idx) begin
                        next_s.state = SQ_IDLE;   // last bit decided (bit 0, or bit 2 in eight-bit mode)
                        next_s.done = 1'b1;
                        next_s.result = next_s.sar;
                    end else begin
                        next_s.sar[s.idx - 4'h1] = 1'b1; // next trial picks tap from upper bits
                        next_s.idx = s.idx - 4'h1;
                    end
                end
            end
            default: begin
                next_s.state = SQ_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '{state: SQ_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // the trial word doubles as the resistor-string tap code
    assign tap_o = s.sar;
    assign sampling_o = (s.state == SQ_SAMPLE);
    assign holding_o = (s.state == SQ_CONVERT); // held until the conversion ends
    assign done_o = s.done;
    assign result_o = s.result;
endmodule

// *** tb_top.sv ***
// tb_top.sv - register-level tests of the converter control
// assumes: sadc_analog_model stands in for the analog side
`timescale 1ns/1ps
`include "sadc_defines.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] addr = 20'h00000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic comp;
    logic [2:0] chan;
    logic iref;
    logic gnd;
    logic smp;
    logic [9:0] tap;
    logic irq;
    logic cmp_en;
    int bad_count = 0;
    int n_checks = 0;
    logic [19:0] regs [7] = '{`SADC_ADDR_RES_SEL, `SADC_ADDR_TEST_SEL, `SADC_ADDR_RES_LOW,
        `SADC_ADDR_RES_HIGH, `SADC_ADDR_MODE, `SADC_ADDR_CHAN, 20'hF0000};

    always #10 clk = ~clk;

    sadc_ctrl sadc_ctrl_i (.sys_clk_i(clk), .arst_n_i(rst_n), .cpu_addr_i(addr),
        .cpu_wr_i(wr_s), .cpu_rd_i(rd_s), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .comp_gt_i(comp), .chan_sel_o(chan), .intref_sel_o(iref), .gnd_sel_o(gnd),
        .cmp_enable_o(cmp_en), .sampling_o(smp), .holding_o(), .tap_o(tap),
        .conversion_done_irq_o(irq));
    sadc_analog_model sadc_analog_model_i (.sys_clk_i(clk), .chan_i(chan), .gnd_i(gnd),
        .sampling_i(smp), .tap_i(tap), .comp_o(comp));

    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // strobe drops one edge later, so back-to-back calls never collide
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask

    // irq is a one-cycle pulse, so look after every edge
    task automatic await_irq(input int lim, input logic want);
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < lim && seen !== 1'b1; k++) begin
            @(posedge clk);
            #1 seen = irq;
        end
        chk("done irq", {7'h00, want}, {7'h00, seen});
    endtask

    // stop, configure, enable, then run; results read before the next mode write
    task automatic conv(input logic [2:0] ch, input logic eight, input logic short,
        input logic dis);
        logic [9:0] v;
        logic [7:0] m;
        v = dis ? 10'h000 : 10'(ch * 131 + 37);
        m = {6'h00, short, 1'b1};
        wr(`SADC_ADDR_MODE, 8'h00);
        wr(`SADC_ADDR_RES_SEL, {7'h00, eight});
        wr(`SADC_ADDR_CHAN, {5'h00, ch});
        wr(`SADC_ADDR_MODE, m);
        wr(`SADC_ADDR_MODE, m | 8'h80);
        chk("comparator enable", 8'h01, {7'h00, cmp_en});
        chk("channel", {5'h00, ch}, {5'h00, chan});
        chk("reference", {7'h00, ch == 3'h7}, {7'h00, iref});
        rd(`SADC_ADDR_MODE, m | 8'h80, "run set");
        await_irq(600, 1'b1);
        rd(`SADC_ADDR_MODE, m, "run cleared");
        rd(`SADC_ADDR_RES_HIGH, v[9:2], "result high");
        rd(`SADC_ADDR_RES_LOW, eight ? 8'h00 : {v[1:0], 6'h00}, "result low");
    endtask

    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00, "reset value");
        wr(`SADC_ADDR_RES_SEL, 8'hFF);
        rd(`SADC_ADDR_RES_SEL, 8'h01, "resolution bit");
        wr(`SADC_ADDR_RES_HIGH, 8'hFF);
        rd(`SADC_ADDR_RES_HIGH, 8'h00, "read-only high");
        for (int c = 0; c < 7; c++) conv(3'(c), c[0], c[1], 1'b0);
        wr(`SADC_ADDR_TEST_SEL, 8'h02);
        // the route flop loads on the write edge itself, so look just after it
        #1 chk("ground route", 8'h01, {7'h00, gnd});
        conv(3'h7, 1'b0, 1'b0, 1'b1);
        wr(`SADC_ADDR_TEST_SEL, 8'h00);
        conv(3'h7, 1'b0, 1'b0, 1'b0);
        wr(`SADC_ADDR_MODE, 8'h00);
        wr(`SADC_ADDR_MODE, 8'h80);
        rd(`SADC_ADDR_MODE, 8'h00, "run refused");
        chk("comparator off", 8'h00, {7'h00, cmp_en});
        await_irq(300, 1'b0);
        wr(`SADC_ADDR_MODE, 8'h01);
        wr(`SADC_ADDR_MODE, 8'h81);
        repeat (40) @(posedge clk);
        wr(`SADC_ADDR_MODE, 8'h01);
        await_irq(300, 1'b0);
        rd(`SADC_ADDR_MODE, 8'h01, "aborted run");
        rd(`SADC_ADDR_RES_HIGH, 8'hEE, "kept high");
        wr(`SADC_ADDR_MODE, 8'h1B);
        rd(`SADC_ADDR_MODE, 8'h1B, "mode fields");
        final_report();
    end

    // whole run is near 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule
